// file: rtl/adc_acquire_convert_sequencer.v
// Purpose: acquire/convert sequencer for a 10-bit successive-approximation converter
// Assumes: Avalon-MM slave, single clock, comparator is an external input
// Notes:   acquisition and conversion phases are not visible to software
//
// Behaviour
// [RULE1] zero acquisition code: go stops sampling and converts at once
// [RULE2] software waits acquisition itself when acquisition code is zero
// [RULE3] nonzero code: keep sampling programmed period, then convert automatically
// [RULE4] at end: clear go, set done flag, resume sampling selected channel
// [RULE5] no status shows acquisition end or conversion start; go stays set
// [RULE6] a conversion takes eleven bit periods, one result bit per period; here period 0 only settles and the ten bits come in periods 1..10
// [RULE7] clock select codes give 2,4,8,16,32,64 oscillator periods or rc
// [RULE8] exactly seven conversion clock sources are selectable
// [RULE9] software picks shortest bit period above the minimum
// [RULE10] software keeps oscillator below the maximum for the divider
// [RULE11] with rc clock above 1 MHz software keeps device asleep
// [RULE12] software sets analog pins as inputs or digital level converts
// [RULE13] channel select and pin directions never block a conversion
// [RULE14] port reads return zero for every pin configured analog
// [RULE15] result is readable in the cycle right after conversion ends
// [RULE16] nonzero acquisition codes map to increasing bit period counts
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module adc_acquire_convert_sequencer #(
    parameter NUM_PINS = 16,
    parameter RC_DIV   = `RC_PERIOD_CYC
) (
    input  wire                  ref_clk_in,          // system clock, 50 MHz
    input  wire                  reset_in,            // async reset, high
    input  wire [`ADDR_W-1:0]    avs_address_in,      // byte address
    input  wire                  avs_read_in,         // read strobe
    input  wire                  avs_write_in,        // write strobe
    input  wire [31:0]           avs_writedata_in,    // write data
    input  wire [3:0]            avs_byteenable_in,   // byte lanes
    output reg  [31:0]           avs_readdata_out,    // read data
    output wire                  avs_waitrequest_out, // stall
    input  wire                  comparator_in,       // sar comparator: input above trial level
    input  wire [NUM_PINS-1:0]   pin_level_in,        // digital pin levels
    output reg  [`RESULT_W-1:0]  dac_trial_out,       // trial code to the dac
    output reg                   sampling_out,        // sample switch closed
    output reg  [`CHAN_W-1:0]    channel_select_out,  // analog mux select
    output wire                  irq_out              // level interrupt
);

    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_ACQ  = 2'h1;
    localparam ST_CONV = 2'h2;

    reg  [1:0]            state;
    reg  [1:0]            next_state;
    reg                   go;
    reg  [5:0]            converter_timing_control;
    reg  [NUM_PINS-1:0]   port_analog_config;
    reg  [`RESULT_W-1:0]  conversion_result;
    reg                   conversion_done_flag;
    reg                   irq_mask;
    reg  [4:0]            acq_count;
    reg  [3:0]            bit_count;
    reg                   rd_ack;
    wire                  tick;
    wire                  conv_end;
    wire                  wr_control;
    wire                  wr_go;
    wire [2:0]            acq_code;
    wire [`RESULT_W-1:0]  bit_mask;

    assign acq_code = converter_timing_control[5:3];

    // ----------------------------------------
    // acquisition period decode
    // ----------------------------------------
    // 001..111 give 2,4,6,8,12,16,20 bit periods
    function [4:0] acq_periods;
        input [2:0] code;
        begin
            case (code)
                3'h1:    acq_periods = 5'h02;  // [RULE16]
                3'h2:    acq_periods = 5'h04;
                3'h3:    acq_periods = 5'h06;
                3'h4:    acq_periods = 5'h08;
                3'h5:    acq_periods = 5'h0C;
                3'h6:    acq_periods = 5'h10;
                3'h7:    acq_periods = 5'h14;
                default: acq_periods = 5'h00;
            endcase
        end
    endfunction

    // ----------------------------------------
    // bit period source
    // ----------------------------------------
    bit_period_gen #(
        .RC_DIV     (RC_DIV)
    ) u_tick (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .run_in     (state != ST_IDLE),
        .clk_sel_in (converter_timing_control[2:0]),
        .tick_out   (tick)
    );

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    // writes complete in the cycle they are seen; reads wait one cycle
    assign avs_waitrequest_out = avs_read_in & ~rd_ack;
    assign wr_control = avs_write_in && avs_address_in == `OFF_CONTROL && avs_byteenable_in[0];
    assign wr_go      = wr_control && avs_writedata_in[`CTL_GO_BIT];

    // ----------------------------------------
    // sequencer next state
    // ----------------------------------------
    // neither channel nor direction bits take part here [RULE13]
    assign conv_end = (state == ST_CONV) && tick && (bit_count == `CONV_PERIODS - 4'h1);

    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (wr_go && acq_code == `ACQ_ZERO)
                    next_state = ST_CONV;  // [RULE1]
                else if (wr_go)
                    next_state = ST_ACQ;   // [RULE3]
            end
            ST_ACQ:
            begin
                if (tick && acq_count == 5'h01)
                    next_state = ST_CONV;  // [RULE3]
            end
            ST_CONV:
            begin
                if (conv_end)
                    next_state = ST_IDLE;  // [RULE4]
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // sequencer registers
    // ----------------------------------------
    // one-hot trial bit for the current period; period 0 is the sample settle
    assign bit_mask = (bit_count == 4'h0) ? {`RESULT_W{1'b0}}
                    : ({{(`RESULT_W-1){1'b0}}, 1'b1} << (4'hA - bit_count));

    always @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state         <= ST_IDLE;
            acq_count     <= 5'h00;
            bit_count     <= 4'h0;
            dac_trial_out <= {`RESULT_W{1'b0}};
            sampling_out  <= 1'b1;
        end
        else
        begin
            state <= next_state;
            if (state == ST_IDLE && wr_go)
                acq_count <= acq_periods(acq_code);
            else if (state == ST_ACQ && tick)
                acq_count <= acq_count - 5'h01;
            // sampling stops only when conversion begins
            sampling_out <= (next_state != ST_CONV);  // [RULE1] [RULE4]
            if (state != ST_CONV)
            begin
                bit_count     <= 4'h0;
                dac_trial_out <= {`RESULT_W{1'b0}};
            end
            else if (tick)
            begin
                // keep the trial bit if the input sits above it, then try next
                bit_count <= bit_count + 4'h1;  // [RULE6]
                dac_trial_out <= ((dac_trial_out & ~bit_mask) | (comparator_in ? bit_mask : {`RESULT_W{1'b0}}))
                               | (bit_mask >> 1) | ((bit_count == 4'h0) ? 10'h200 : 10'h000);
            end
        end
    end

    // ----------------------------------------
    // result capture
    // ----------------------------------------
    // latched on the final period so it reads valid the very next cycle
    always @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
            conversion_result <= {`RESULT_W{1'b0}};
        else if (conv_end)
            conversion_result <= (dac_trial_out & ~bit_mask)
                               | (comparator_in ? bit_mask : {`RESULT_W{1'b0}});  // [RULE15]
    end

    // ----------------------------------------
    // go flag and done flag
    // ----------------------------------------
    // go stays set across acquisition and conversion alike [RULE5]
    always @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            go                   <= 1'b0;
            conversion_done_flag <= 1'b0;
        end
        else
        begin
            if (conv_end)
                go <= 1'b0;  // [RULE4]
            else if (wr_go)
                go <= 1'b1;
            // the end event wins over a clear written in the same cycle
            if (conv_end)
                conversion_done_flag <= 1'b1;  // [RULE4]
            else if (avs_write_in && avs_address_in == `OFF_IRQ_STATUS
                     && avs_byteenable_in[0] && avs_writedata_in[0])
                conversion_done_flag <= 1'b0;
        end
    end

    assign irq_out = conversion_done_flag & irq_mask;

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    // timing changes during a conversion are accepted but are a software fault
    always @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            converter_timing_control <= `TIMING_RESET;
            port_analog_config       <= `PORT_CFG_RESET;
            channel_select_out       <= {`CHAN_W{1'b0}};
            irq_mask                 <= 1'b0;
        end
        else if (avs_write_in)
        begin
            if (wr_control)
                channel_select_out <= avs_writedata_in[`CTL_CHAN_LSB+`CHAN_W-1:`CTL_CHAN_LSB];
            if (avs_address_in == `OFF_TIMING && avs_byteenable_in[0])
                converter_timing_control <= avs_writedata_in[5:0];
            if (avs_address_in == `OFF_PORT_CFG && avs_byteenable_in[0])
                port_analog_config[7:0] <= avs_writedata_in[7:0];
            if (avs_address_in == `OFF_PORT_CFG && avs_byteenable_in[1])
                port_analog_config[NUM_PINS-1:8] <= avs_writedata_in[NUM_PINS-1:8];
            if (avs_address_in == `OFF_IRQ_MASK && avs_byteenable_in[0])
                irq_mask <= avs_writedata_in[0];
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // unmapped addresses read as zero; analog pins read low [RULE14]
    always @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rd_ack           <= 1'b0;
            avs_readdata_out <= 32'h00000000;
        end
        else
        begin
            rd_ack <= avs_read_in & ~rd_ack;
            if (avs_read_in && !rd_ack)
            begin
                case (avs_address_in)
                    `OFF_CONTROL:
                        avs_readdata_out <= {26'h0, channel_select_out, 1'b0, go};
                    `OFF_TIMING:
                        avs_readdata_out <= {26'h0, converter_timing_control};
                    `OFF_PORT_CFG:
                        avs_readdata_out <= {{(32-NUM_PINS){1'b0}}, port_analog_config};
                    `OFF_RESULT:
                        avs_readdata_out <= {22'h0, conversion_result};
                    `OFF_IRQ_STATUS:
                        avs_readdata_out <= {31'h0, conversion_done_flag};
                    `OFF_IRQ_MASK:
                        avs_readdata_out <= {31'h0, irq_mask};
                    `OFF_PORT_READ:
                        avs_readdata_out <= {{(32-NUM_PINS){1'b0}}, pin_level_in & ~port_analog_config};
                    default:
                        avs_readdata_out <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

// file: rtl/adc_seq_consts.vh
// Purpose: constants for the converter acquire/convert sequencer
// Assumes: 32-bit Avalon-MM register words, byte addresses
// Notes:   register offsets are word aligned
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// register byte offsets
`define OFF_CONTROL        5'h00
`define OFF_TIMING         5'h04
`define OFF_PORT_CFG       5'h08
`define OFF_RESULT         5'h0C
`define OFF_IRQ_STATUS     5'h10
`define OFF_IRQ_MASK       5'h14
`define OFF_PORT_READ      5'h18
`define ADDR_W             5

// control register fields
`define CTL_GO_BIT         0
`define CTL_CHAN_LSB       2
`define CHAN_W             4

// timing control fields
`define TIM_CLKSEL_LSB     0
`define TIM_ACQ_LSB        3
`define ACQ_ZERO           3'h0

// conversion length in bit periods
`define CONV_PERIODS       4'hB
`define RESULT_W           10

// internal rc bit period, in ns
`define RC_PERIOD_NS       4000
`define CLK_PERIOD_NS      20
`define RC_PERIOD_CYC      (`RC_PERIOD_NS / `CLK_PERIOD_NS)

// reset values
`define TIMING_RESET       6'h00
`define PORT_CFG_RESET     16'hFFFF

`endif

// file: rtl/bit_period_gen.v
// Purpose: makes one pulse per conversion bit period from the system clock
// Assumes: clock select code is stable while a conversion runs
// Notes:   the rc option is modelled as a fixed divider of the system clock
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module bit_period_gen #(
    parameter RC_DIV = `RC_PERIOD_CYC
) (
    input  wire       ref_clk_in,        // system clock
    input  wire       reset_in,          // async reset, high
    input  wire       run_in,            // divider runs while high
    input  wire [2:0] clk_sel_in,        // conversion clock select code
    output reg        tick_out           // one-cycle pulse per bit period
);

    reg  [7:0] count;
    wire [7:0] limit;

    // ----------------------------------------
    // period decode
    // ----------------------------------------
    // low bit pair selects rc (x11), else bit2 doubles the base 2/8/32
    function [7:0] period_of;
        input [2:0] sel;
        begin
            case (sel[1:0])
                2'h0:    period_of = sel[2] ? 8'h04 : 8'h02;  // [RULE7]
                2'h1:    period_of = sel[2] ? 8'h10 : 8'h08;  // [RULE7]
                2'h2:    period_of = sel[2] ? 8'h40 : 8'h20;  // [RULE7]
                default: period_of = RC_DIV[7:0];             // [RULE8]
            endcase
        end
    endfunction

    assign limit = period_of(clk_sel_in);

    // counts system clocks; restarts whenever the sequencer is idle
    always @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            count    <= 8'h00;
            tick_out <= 1'b0;
        end
        else if (!run_in)
        begin
            count    <= 8'h00;
            tick_out <= 1'b0;
        end
        else if (count == limit - 8'h01)
        begin
            count    <= 8'h00;
            tick_out <= 1'b1;
        end
        else
        begin
            count    <= count + 8'h01;
            tick_out <= 1'b0;
        end
    end

endmodule

// file: verif/adc_seq_assertions.sv
// Purpose: bus and sequencing checks for the converter sequencer
// Assumes: sees only the top-level ports; timing and mask shadowed from bus writes
// Notes:   conversion length allows one cycle of divider phase slack
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module adc_seq_assertions #(
    parameter NUM_PINS = 16,
    parameter RC_DIV   = `RC_PERIOD_CYC
) (
    input wire                 ref_clk_in,          // system clock
    input wire                 reset_in,            // async reset, high
    input wire [`ADDR_W-1:0]   avs_address_in,      // byte address
    input wire                 avs_read_in,         // read strobe
    input wire                 avs_write_in,        // write strobe
    input wire [31:0]          avs_writedata_in,    // write data
    input wire [3:0]           avs_byteenable_in,   // byte lanes
    input wire                 avs_waitrequest_out, // stall
    input wire                 sampling_out,        // sample switch
    input wire [`CHAN_W-1:0]   channel_select_out,  // mux select
    input wire                 irq_out              // interrupt
);
default clocking cb @(posedge ref_clk_in); endclocking
default disable iff (reset_in);
// ---------------------------------------------------------------
// shadow state
// ---------------------------------------------------------------
reg  [2:0]  sel_q;
reg  [2:0]  acq_q;
reg         mask_q;
reg  [15:0] low_cnt;
reg         busy_q;
reg         samp_q;
wire        wr_ok;
wire        go_wr;
wire [15:0] conv_cyc;
function [15:0] div_of(input [2:0] s);
    case (s)
        3'h0: div_of = 16'h0002;
        3'h4: div_of = 16'h0004;
        3'h1: div_of = 16'h0008;
        3'h5: div_of = 16'h0010;
        3'h2: div_of = 16'h0020;
        3'h6: div_of = 16'h0040;
        default: div_of = RC_DIV[15:0];
    endcase
endfunction
assign wr_ok    = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
assign go_wr    = wr_ok && avs_address_in == `OFF_CONTROL && avs_writedata_in[0];
assign conv_cyc = 16'h000B * div_of(sel_q);
// low_cnt measures how long the sample switch stays open
always @(posedge ref_clk_in or posedge reset_in)
begin
    if (reset_in)
    begin
        sel_q   <= 3'h0;
        acq_q   <= 3'h0;
        mask_q  <= 1'b0;
        low_cnt <= 16'h0000;
        busy_q  <= 1'b0;
        samp_q  <= 1'b1;
    end
    else
    begin
        low_cnt <= sampling_out ? 16'h0000 : low_cnt + 16'h0001;
        // busy_q marks a run in progress, so a repeated go is not taken for a fresh start
        samp_q  <= sampling_out;
        if (go_wr)
            busy_q <= 1'b1;
        else if (sampling_out && !samp_q)
            busy_q <= 1'b0;
        if (wr_ok && avs_address_in == `OFF_TIMING)
        begin
            sel_q <= avs_writedata_in[2:0];
            acq_q <= avs_writedata_in[5:3];
        end
        if (wr_ok && avs_address_in == `OFF_IRQ_MASK)
            mask_q <= avs_writedata_in[0];
    end
end
// ---------------------------------------------------------------
// properties
// ---------------------------------------------------------------
sequence s_read_ans;
    avs_waitrequest_out ##1 !avs_waitrequest_out;
endsequence
property p_read_wait;
    $rose(avs_read_in) |-> s_read_ans;
endproperty
a_read_wait: assert property (p_read_wait) else $error("read not answered on second edge");
property p_write_nowait;
    avs_write_in |-> !avs_waitrequest_out;
endproperty
a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
property p_go_now;
    go_wr && !busy_q && acq_q == 3'h0 && sampling_out |=> !sampling_out;
endproperty
a_go_now: assert property (p_go_now) else $error("sampling kept after go");
property p_go_acq;
    go_wr && !busy_q && acq_q != 3'h0 && sampling_out |=> sampling_out [*4];
endproperty
a_go_acq: assert property (p_go_acq) else $error("acquisition cut short");
property p_conv_len;
    $rose(sampling_out) |-> low_cnt + 16'h0001 >= conv_cyc && low_cnt <= conv_cyc + 16'h0001;
endproperty
a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
property p_done_irq;
    $rose(sampling_out) && mask_q |-> irq_out;
endproperty
a_done_irq: assert property (p_done_irq) else $error("no interrupt at end");
property p_w1c;
    wr_ok && avs_address_in == `OFF_IRQ_STATUS && avs_writedata_in[0] && sampling_out |=> !irq_out;
endproperty
a_w1c: assert property (p_w1c) else $error("done flag not cleared");
property p_chan;
    wr_ok && avs_address_in == `OFF_CONTROL |=> channel_select_out == $past(avs_writedata_in[5:2]);
endproperty
a_chan: assert property (p_chan) else $error("channel select not taken");
property p_irq_end;
    $rose(irq_out) && !$past(avs_write_in) |-> sampling_out;
endproperty
a_irq_end: assert property (p_irq_end) else $error("interrupt before end");
endmodule
bind adc_acquire_convert_sequencer adc_seq_assertions #(.NUM_PINS(NUM_PINS), .RC_DIV(RC_DIV)) u_chk (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_waitrequest_out(avs_waitrequest_out),
    .sampling_out(sampling_out), .channel_select_out(channel_select_out), .irq_out(irq_out));

// file: verif/testbench.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: rc divider shortened to 4 clocks
// Notes:   comparator modelled from a digital target level
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module testbench;
reg         ref_clk_in = 1'b0;
reg         reset_in = 1'b1;
reg  [4:0]  avs_address_in = 5'h00;
reg         avs_read_in = 1'b0;
reg         avs_write_in = 1'b0;
reg  [31:0] avs_writedata_in = 32'h0;
reg  [3:0]  avs_byteenable_in = 4'hF;
reg         comparator_in = 1'b0;
reg  [15:0] pin_level_in = 16'hA5C3;
reg  [9:0]  level = 10'h000;
wire [31:0] avs_readdata_out;
wire        avs_waitrequest_out;
wire [9:0]  dac_trial_out;
wire        sampling_out;
wire [3:0]  channel_select_out;
wire        irq_out;
integer     num_errors = 0;
integer     num_checks = 0;
integer     i;
reg  [31:0] r;
reg  [31:0] rows [0:7];
adc_acquire_convert_sequencer #(.NUM_PINS(16), .RC_DIV(4)) i_adc_acquire_convert_sequencer (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .comparator_in(comparator_in),
    .pin_level_in(pin_level_in), .dac_trial_out(dac_trial_out), .sampling_out(sampling_out),
    .channel_select_out(channel_select_out), .irq_out(irq_out));
// 50 MHz clock
always #10 ref_clk_in = ~ref_clk_in;
// input counts as above the trial when target >= trial, so the result equals target
always @(posedge ref_clk_in) comparator_in <= (level >= dac_trial_out);
task test_done;
begin
    if (num_errors == 0 && num_checks > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
end
endtask
task chk(input string what, input [31:0] exp, input [31:0] got);
begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
        num_errors = num_errors + 1;
        $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
end
endtask
// one bus cycle, held until waitrequest is seen low
task bus(input is_rd, input [4:0] a, input [31:0] d, output [31:0] q);
    integer n;
begin
    @(posedge ref_clk_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_read_in      <= is_rd;
    avs_write_in     <= !is_rd;
    n = 0;
    @(posedge ref_clk_in);
    while (avs_waitrequest_out !== 1'b0 && n < 100)
    begin
        n = n + 1;
        @(posedge ref_clk_in);
    end
    // a slave that never answers counts as a mismatch
    if (n >= 100)
        num_errors = num_errors + 1;
    q = avs_readdata_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
end
endtask
task wr(input [4:0] a, input [31:0] d);
    reg [31:0] q;
begin
    bus(1'b0, a, d, q);
end
endtask
task rd(input string what, input [4:0] a, input [31:0] exp);
    reg [31:0] q;
begin
    bus(1'b1, a, 32'h0, q);
    chk(what, exp, q);
end
endtask
// hang guard, well above the longest row
initial
begin
    repeat (40000) @(posedge ref_clk_in);
    num_errors = num_errors + 1;
    test_done;
end
// rows: {clock select, acquisition code, channel, target level}
initial
begin
    rows[0] = 32'h00000; rows[1] = 32'h84FFF; rows[2] = 32'h29600; rows[3] = 32'hADDFF;
    rows[4] = 32'h52555; rows[5] = 32'hD7EAA; rows[6] = 32'h7A801; rows[7] = 32'hFF3FE;
    repeat (12) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    chk("sampling", 32'h1, sampling_out);
    rd("timing", `OFF_TIMING, 32'h0);
    rd("port cfg", `OFF_PORT_CFG, 32'hFFFF);
    wr(5'h1C, 32'hFFFF_FFFF);
    rd("unmapped", 5'h1C, 32'h0);
    wr(`OFF_IRQ_MASK, 32'h1);
    for (i = 0; i < 8; i = i + 1)
    begin
        r = rows[i];
        level <= r[9:0];
        wr(`OFF_TIMING, {26'h0, r[16:14], r[19:17]});
        wr(`OFF_CONTROL, {26'h0, r[13:10], 2'h0});
        repeat (4) @(posedge ref_clk_in);
        wr(`OFF_CONTROL, {26'h0, r[13:10], 2'h1});
        rd("go busy", `OFF_CONTROL, {26'h0, r[13:10], 2'h1});
        chk("channel", r[13:10], channel_select_out);
        while (irq_out !== 1'b1) @(posedge ref_clk_in);
        rd("result", `OFF_RESULT, r[9:0]);
        rd("go done", `OFF_CONTROL, {26'h0, r[13:10], 2'h0});
        chk("resampling", 32'h1, sampling_out);
        rd("status", `OFF_IRQ_STATUS, 32'h1);
        wr(`OFF_IRQ_STATUS, 32'h1);
    end
    // analog pins read low; upper config byte gated by its lane
    wr(`OFF_PORT_CFG, 32'h00F0);
    rd("port read", `OFF_PORT_READ, 32'hA503);
    avs_byteenable_in <= 4'h1;
    wr(`OFF_PORT_CFG, 32'hFFFF);
    avs_byteenable_in <= 4'hF;
    rd("port read", `OFF_PORT_READ, 32'hA500);
    // masked completion, second go while busy must not start another run
    wr(`OFF_IRQ_MASK, 32'h0);
    wr(`OFF_TIMING, 32'h0);
    level <= 10'h0AB;
    wr(`OFF_CONTROL, 32'h1);
    wr(`OFF_CONTROL, 32'h1);
    repeat (40) @(posedge ref_clk_in);
    chk("masked irq", 32'h0, irq_out);
    rd("status", `OFF_IRQ_STATUS, 32'h1);
    rd("result", `OFF_RESULT, 32'h0AB);
    wr(`OFF_IRQ_STATUS, 32'h1);
    repeat (40) @(posedge ref_clk_in);
    rd("status", `OFF_IRQ_STATUS, 32'h0);
    // reset in mid-conversion
    wr(`OFF_CONTROL, 32'h1);
    repeat (5) @(posedge ref_clk_in);
    reset_in <= 1'b1;
    @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    chk("sampling", 32'h1, sampling_out);
    chk("irq", 32'h0, irq_out);
    rd("go", `OFF_CONTROL, 32'h0);
    test_done;
end
endmodule
